/* File: verification/acpi_pm1_button_sleep_control_test.sv */
/*
 * Self-checking bench for the power management enable and control registers.
 * Assumes the design package is compiled first and short tick and override counts.
 */
`timescale 1ns/1ns
`define check_eq(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module acpi_pm1_button_sleep_control_test;
	localparam int TICK = 8;
	localparam int OVR  = 10;
	logic                        clk;
	logic                        rst;
	pm1_ctrl_pkg::io_req_s       io_req;
	logic [7:0]                  io_rdata_q;
	pm1_ctrl_pkg::status_flags_s status_clear;
	pm1_ctrl_pkg::status_flags_s status_q;
	logic                        sleep_redirect_select;
	logic                        system_sleeping;
	logic                        button_in;
	logic                        sci_q;
	logic                        smi_q;
	logic                        wake_q;
	logic                        power_on_request_n_q;
	logic                        power_on_request_n_oe_q;
	logic                        press;
	logic                        supply_on;
	int                          n_fail;
	int                          n_checks;
	int                          n_cycles;
	int                          wake_cnt;
	acpi_pm1_button_sleep_control #(.TICK_CYCLES(TICK), .OVERRIDE_TICKS(OVR)) u_dut (
		.clk(clk), .rst(rst), .io_req(io_req), .io_rdata_q(io_rdata_q), .status_clear(status_clear),
		.status_q(status_q), .sleep_redirect_select(sleep_redirect_select), .system_sleeping(system_sleeping),
		.button_in(button_in), .sci_q(sci_q), .smi_q(smi_q), .wake_q(wake_q),
		.power_on_request_n_q(power_on_request_n_q), .power_on_request_n_oe_q(power_on_request_n_oe_q));
	power_switch_supply u_model (
		.clk(clk), .press(press), .power_on_request_n_q(power_on_request_n_q),
		.power_on_request_n_oe_q(power_on_request_n_oe_q), .button_in(button_in), .supply_on(supply_on));
	initial clk = 1'b0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		n_cycles <= n_cycles + 1;
		if (wake_q === 1'b1) wake_cnt <= wake_cnt + 1;
		if (n_cycles == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks=%0d failures=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic io_write(input logic [4:0] a, input logic [7:0] d);
		// One idle edge first, so back-to-back calls never reassign the strobe in one time step
		@(posedge clk) #1;
		io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk) #1;
		io_req = '0;
	endtask
	task automatic io_read(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk) #1;
		io_req = '0;
		d = io_rdata_q;
	endtask
	task automatic clear_flags();
		@(posedge clk) #1;
		status_clear = 3'h7;
		@(posedge clk) #1;
		status_clear = '0;
	endtask
	// Presses the button and waits for the status flag, or a generous bound
	task automatic push(input logic hold);
		press = 1'b1;
		for (int i = 0; i < 3 * TICK + 20 && status_q.power_button_status !== 1'b1; i++) @(posedge clk) #1;
		`check_eq(status_q.power_button_status, 1'b1)
		if (!hold) begin
			press = 1'b0;
			repeat (3 * TICK + 10) @(posedge clk) #1;
		end
	endtask
	task automatic quiet_power(input logic [7:0] exp_smi_flag);
		repeat (3 * TICK) @(posedge clk) #1;
		`check_eq(supply_on, 1'b1)
		`check_eq(status_q.sleep_request_smi_flag, exp_smi_flag[0])
	endtask
	task automatic t_registers();
		logic [7:0] d;
		logic [4:0] addrs [6] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1f};
		logic [7:0] exp_w [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h1e, 8'h00};
		logic [7:0] wr_w [6]  = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h3e, 8'h00};
		for (int i = 0; i < 6; i++) begin
			io_read(addrs[i], d);
			`check_eq(d, 8'h00)
		end
		clear_flags();
		// Every defined bit set and reserved bits kept at zero, so the trigger and type 111 are exercised
		for (int i = 0; i < 6; i++) io_write(addrs[i], wr_w[i]);
		for (int i = 0; i < 6; i++) begin
			io_read(addrs[i], d);
			`check_eq(d, exp_w[i])
		end
		`check_eq(status_q.sleep_request_smi_flag, 1'b1)
		quiet_power(8'h01);
	endtask
	task automatic t_sci(input logic btn_en, input logic sci_global_enable, input logic sleeping);
		io_write(5'h03, {7'h00, btn_en});
		io_write(5'h04, {7'h00, sci_global_enable});
		io_write(5'h05, 8'h00);
		system_sleeping = sleeping;
		clear_flags();
		push(1'b1);
		@(posedge clk) #1;
		`check_eq(sci_q, btn_en & sci_global_enable & ~sleeping)
		press = 1'b0;
		repeat (3 * TICK + 10) @(posedge clk) #1;
		system_sleeping = 1'b0;
		clear_flags();
	endtask
	task automatic t_override();
		int w;
		io_write(5'h05, 8'h02);
		clear_flags();
		push(1'b1);
		for (int i = 0; i < (OVR + 4) * TICK + 20 && status_q.button_override_status !== 1'b1; i++)
			@(posedge clk) #1;
		`check_eq(status_q.button_override_status, 1'b1)
		`check_eq(status_q.power_button_status, 1'b0)
		@(posedge clk) #1;
		`check_eq(supply_on, 1'b0)
		press = 1'b0;
		repeat (3 * TICK + 10) @(posedge clk) #1;
		io_write(5'h05, 8'h00);
		w = wake_cnt;
		push(1'b0);
		`check_eq(supply_on, 1'b1)
		`check_eq(wake_cnt - w, 1)
		clear_flags();
	endtask
	task automatic t_soft_off();
		int k;
		sleep_redirect_select = 1'b0;
		clear_flags();
		io_write(5'h05, 8'h20);
		`check_eq(status_q.sleep_request_smi_flag, 1'b1)
		`check_eq(smi_q, 1'b0)
		k = 1;
		while (k < 3 * TICK && power_on_request_n_oe_q !== 1'b0) begin
			@(posedge clk) #1;
			k++;
		end
		// Window of one to two tick periods, plus the register stages at each end
		`check_eq(k >= TICK + 1 && k <= 2 * TICK + 2, 1'b1)
		`check_eq(supply_on, 1'b0)
		push(1'b0);
		`check_eq(supply_on, 1'b1)
		clear_flags();
		io_write(5'h05, 8'h00);
		quiet_power(8'h00);
	endtask
	task automatic t_redirect();
		sleep_redirect_select = 1'b1;
		io_write(5'h05, 8'h20);
		`check_eq(smi_q, 1'b1)
		`check_eq(status_q.sleep_request_smi_flag, 1'b1)
		@(posedge clk) #1;
		`check_eq(smi_q, 1'b0)
		quiet_power(8'h01);
		sleep_redirect_select = 1'b0;
	endtask
	initial begin
		n_fail = 0;
		n_checks = 0;
		n_cycles = 0;
		wake_cnt = 0;
		rst = 1'b1;
		io_req = '0;
		status_clear = '0;
		sleep_redirect_select = 1'b0;
		system_sleeping = 1'b0;
		press = 1'b0;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		t_registers();
		t_sci(1'b1, 1'b1, 1'b0);
		t_sci(1'b0, 1'b1, 1'b0);
		t_sci(1'b1, 1'b0, 1'b0);
		t_sci(1'b1, 1'b1, 1'b1);
		`check_eq(wake_cnt >= 1, 1'b1)
		t_override();
		t_soft_off();
		t_redirect();
		end_sim();
	end
endmodule // acpi_pm1_button_sleep_control_test

/* File: verification/power_switch_supply.sv */
/*
 * Model of the power button switch and the system supply that it commands.
 * Assumes the bench moves press just after a clock edge; the supply pin has a pull-up.
 */
`timescale 1ns/1ns
module power_switch_supply #(
	parameter int CONTACT_DELAY = 3
) (
	input  wire logic clk,
	input  wire logic press,
	input  wire logic power_on_request_n_q,
	input  wire logic power_on_request_n_oe_q,
	output logic      button_in,
	output logic      supply_on
);
	logic [15:0] contact_q;
	logic        pin_level;

	// A switch lags the finger by a few cycles, so the sync and tick sampling see a late edge
	initial contact_q = '0;
	always @(posedge clk) begin
		contact_q <= {contact_q[14:0], press};
	end
	assign button_in = contact_q[CONTACT_DELAY];

	// Floating pin is pulled up, which the supply reads as off
	assign pin_level = power_on_request_n_oe_q ? power_on_request_n_q : 1'b1;
	assign supply_on = ~pin_level;
endmodule // power_switch_supply

/* File: verilog/acpi_pm1_button_sleep_control.sv */
/*
 * Power management enable and control registers with power button
 * event gating, button override and soft-off sequencing.
 * Assumes a same-clock I/O port decoded to the block, status clears and
 * the sleep redirect select coming from logic on clk, and the button on a pin.
 */
// Function
// - Reserved bits of enable and control registers always read zero.
// - Button raises SCI only while the button event enable is set.
// - Every button press sets the button status flag, regardless of enable.
// - Global SCI enable gates every event onto the SCI output.
// - With override enabled, holding the button over four seconds turns power off.
// - Override clears button status and sets override status.
// - Sleep type field selects the state; zero means soft off.
// - Soft off releases the power pin one to two 32 kHz periods later.
// - Sleep trigger is write-only and reads as zero.
// - Redirect clear: trigger with sleep type zero starts soft off after one to two ticks; other types start nothing.
// - Redirect set: trigger starts no sleep and raises an SMI.
// - Every trigger write of one sets the sleep request SMI flag.
// - Writing zero to the trigger does nothing.
// - Button press while sleeping or off always makes a wake event.
`timescale 1ns/1ns
module acpi_pm1_button_sleep_control #(
	parameter int TICK_CYCLES    = pm1_ctrl_pkg::TICK_CYCLES,
	parameter int OVERRIDE_TICKS = pm1_ctrl_pkg::OVERRIDE_TICKS
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire pm1_ctrl_pkg::io_req_s       io_req,
	output logic [7:0]                       io_rdata_q,
	input  wire pm1_ctrl_pkg::status_flags_s status_clear,
	output pm1_ctrl_pkg::status_flags_s      status_q,
	input  wire logic                        sleep_redirect_select,
	input  wire logic                        system_sleeping,
	input  wire logic                        button_in,
	output logic                             sci_q,
	output logic                             smi_q,
	output logic                             wake_q,
	output logic                             power_on_request_n_q,
	output logic                             power_on_request_n_oe_q
);
	localparam int DW = $clog2(TICK_CYCLES);

	logic [DW-1:0]               div_q, div_d;
	logic                        tick_q, tick_d;
	logic                        btn_en_q, btn_en_d;
	logic                        sci_global_enable_q, sci_global_enable_d;
	logic                        or_en_q, or_en_d;
	logic [2:0]                  type_q, type_d;
	logic                        pending_q, pending_d;
	logic [1:0]                  pend_ticks_q, pend_ticks_d;
	logic                        active_q, active_d;
	pm1_ctrl_pkg::status_flags_s status_d;
	logic [7:0]                  rdata_d;
	logic                        sci_d, smi_d, wake_d;
	logic                        trigger_wr, sleeping_now;
	logic                        press_pulse, override_pulse;

	button_override_timer #(
		.OVERRIDE_TICKS (OVERRIDE_TICKS)
	) u_timer (
		.clk              (clk),
		.rst              (rst),
		.tick             (tick_q),
		.button_in        (button_in),
		.override_enable  (or_en_q),
		.press_pulse_q    (press_pulse),
		.override_pulse_q (override_pulse)
	);

	function automatic logic hit(input pm1_ctrl_pkg::io_req_s r, input logic [4:0] ofs);
		hit = (r.addr == ofs);
	endfunction

	assign sleeping_now = !active_q || system_sleeping;

	always_comb begin
		div_d        = div_q + DW'(1);
		tick_d       = 1'b0;
		btn_en_d     = btn_en_q;
		sci_global_enable_d     = sci_global_enable_q;
		or_en_d      = or_en_q;
		type_d       = type_q;
		pending_d    = pending_q;
		pend_ticks_d = pend_ticks_q;
		active_d     = active_q;
		status_d     = status_q;
		smi_d        = 1'b0;
		wake_d       = 1'b0;
		trigger_wr   = 1'b0;
		rdata_d      = io_rdata_q;

		if (div_q == DW'(TICK_CYCLES - 1)) begin
			div_d  = '0;
			tick_d = 1'b1;
		end

		// Only defined bits are stored, so reserved bits cannot read back nonzero
		if (io_req.wr) begin
			if (hit(io_req, pm1_ctrl_pkg::OFS_ENABLE_TWO)) begin
				btn_en_d = io_req.wdata[pm1_ctrl_pkg::BIT_BUTTON_EVENT_EN];
			end else if (hit(io_req, pm1_ctrl_pkg::OFS_CONTROL_ONE)) begin
				sci_global_enable_d = io_req.wdata[pm1_ctrl_pkg::BIT_SCI_GLOBAL_EN];
			end else if (hit(io_req, pm1_ctrl_pkg::OFS_CONTROL_TWO)) begin
				or_en_d    = io_req.wdata[pm1_ctrl_pkg::BIT_OVERRIDE_EN];
				type_d     = io_req.wdata[pm1_ctrl_pkg::SLEEP_TYPE_MSB:pm1_ctrl_pkg::SLEEP_TYPE_LSB];
				trigger_wr = io_req.wdata[pm1_ctrl_pkg::BIT_SLEEP_TRIGGER];
			end
		end

		// Counting two ticks from an arbitrary phase gives one to two tick periods
		if (pending_q && tick_q) begin
			if (pend_ticks_q == 2'(pm1_ctrl_pkg::SLEEP_DELAY_TICKS - 1)) begin
				pending_d = 1'b0;
				active_d  = 1'b0;
			end else begin
				pend_ticks_d = pend_ticks_q + 2'h1;
			end
		end

		// Clears first so a same-cycle hardware set wins
		if (status_clear.power_button_status) status_d.power_button_status = 1'b0;
		if (status_clear.button_override_status) status_d.button_override_status = 1'b0;
		if (status_clear.sleep_request_smi_flag) status_d.sleep_request_smi_flag = 1'b0;

		if (trigger_wr) begin
			status_d.sleep_request_smi_flag = 1'b1;
			if (sleep_redirect_select) begin
				smi_d = 1'b1;
			end else if (type_d == pm1_ctrl_pkg::SLEEP_TYPE_OFF) begin
				pending_d    = 1'b1;
				pend_ticks_d = 2'h0;
			end
			// Other sleep types fall through with no transition
		end

		if (press_pulse) begin
			status_d.power_button_status = 1'b1;
			if (sleeping_now) begin
				// The button always wakes, enable or not
				wake_d   = 1'b1;
				active_d = 1'b1;
			end
		end

		if (override_pulse) begin
			status_d.power_button_status    = 1'b0;
			status_d.button_override_status = 1'b1;
			active_d                        = 1'b0;
			pending_d                       = 1'b0;
		end

		// Working state only; global enable gates the event
		sci_d = sci_global_enable_q && btn_en_q && status_q.power_button_status && !sleeping_now;

		if (io_req.rd) begin
			rdata_d = 8'h00;
			if (hit(io_req, pm1_ctrl_pkg::OFS_ENABLE_TWO)) begin
				rdata_d[pm1_ctrl_pkg::BIT_BUTTON_EVENT_EN] = btn_en_q;
			end else if (hit(io_req, pm1_ctrl_pkg::OFS_CONTROL_ONE)) begin
				rdata_d[pm1_ctrl_pkg::BIT_SCI_GLOBAL_EN] = sci_global_enable_q;
			end else if (hit(io_req, pm1_ctrl_pkg::OFS_CONTROL_TWO)) begin
				// Trigger bit is left at zero
				rdata_d[pm1_ctrl_pkg::BIT_OVERRIDE_EN] = or_en_q;
				rdata_d[pm1_ctrl_pkg::SLEEP_TYPE_MSB:pm1_ctrl_pkg::SLEEP_TYPE_LSB] = type_q;
			end
		end
	end

	// Battery reset clears every field; power stays on until told otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			div_q                   <= '0;
			tick_q                  <= 1'b0;
			btn_en_q                <= pm1_ctrl_pkg::REG_RESET[0];
			sci_global_enable_q                <= pm1_ctrl_pkg::REG_RESET[0];
			or_en_q                 <= pm1_ctrl_pkg::REG_RESET[1];
			type_q                  <= pm1_ctrl_pkg::REG_RESET[4:2];
			pending_q               <= 1'b0;
			pend_ticks_q            <= 2'h0;
			active_q                <= 1'b1;
			status_q                <= '0;
			io_rdata_q              <= 8'h00;
			sci_q                   <= 1'b0;
			smi_q                   <= 1'b0;
			wake_q                  <= 1'b0;
			power_on_request_n_q    <= 1'b0;
			power_on_request_n_oe_q <= 1'b1;
		end else begin
			div_q                   <= div_d;
			tick_q                  <= tick_d;
			btn_en_q                <= btn_en_d;
			sci_global_enable_q                <= sci_global_enable_d;
			or_en_q                 <= or_en_d;
			type_q                  <= type_d;
			pending_q               <= pending_d;
			pend_ticks_q            <= pend_ticks_d;
			active_q                <= active_d;
			status_q                <= status_d;
			io_rdata_q              <= rdata_d;
			sci_q                   <= sci_d;
			smi_q                   <= smi_d;
			wake_q                  <= wake_d;
			power_on_request_n_q    <= 1'b0;
			// Floating the pin is what turns the supply off
			power_on_request_n_oe_q <= active_d;
		end
	end

	// Cycles since the soft-off request, for the delay check only
	logic [15:0] dly_cnt_q;
	always_ff @(posedge clk) begin
		// Only a soft-off request restarts the count; other trigger writes leave a pending delay alone
		if (rst || (trigger_wr && !sleep_redirect_select && type_d == pm1_ctrl_pkg::SLEEP_TYPE_OFF))
			dly_cnt_q <= 16'h0000;
		else if (dly_cnt_q != 16'hffff) dly_cnt_q <= dly_cnt_q + 16'h0001;
	end

	localparam int DLY_MIN = TICK_CYCLES;
	localparam int DLY_MAX = 2 * TICK_CYCLES + 2;

	chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		io_req.rd && (io_req.addr == pm1_ctrl_pkg::OFS_ENABLE_ONE) |=> io_rdata_q == 8'h00)
		else $error("reserved enable register read nonzero");

	chk_sci_gated: assert property (@(posedge clk) disable iff (rst)
		sci_q |-> $past(sci_global_enable_q) && $past(btn_en_q) && $past(status_q.power_button_status))
		else $error("SCI raised without both enables");

	chk_sci_global: assert property (@(posedge clk) disable iff (rst)
		!sci_global_enable_q |=> !sci_q)
		else $error("SCI raised with global enable clear");

	chk_press_status: assert property (@(posedge clk) disable iff (rst)
		press_pulse && !override_pulse |=> status_q.power_button_status)
		else $error("button press did not set status");

	chk_override_effect: assert property (@(posedge clk) disable iff (rst)
		override_pulse |=> !status_q.power_button_status && status_q.button_override_status
			&& !power_on_request_n_oe_q)
		else $error("override did not swap flags and power off");

	chk_off_delay: assert property (@(posedge clk) disable iff (rst)
		$fell(power_on_request_n_oe_q) && $past(pending_q) && !$past(override_pulse)
			|-> dly_cnt_q >= 16'(DLY_MIN) && dly_cnt_q <= 16'(DLY_MAX))
		else $error("soft-off release outside one to two ticks");

	chk_trigger_reads_zero: assert property (@(posedge clk) disable iff (rst)
		io_req.rd |=> !io_rdata_q[pm1_ctrl_pkg::BIT_SLEEP_TRIGGER])
		else $error("sleep trigger read back as one");

	chk_redirect_smi: assert property (@(posedge clk) disable iff (rst)
		trigger_wr && sleep_redirect_select && !pending_q |=> smi_q && !pending_q)
		else $error("redirected trigger did not raise SMI only");

	chk_smi_flag: assert property (@(posedge clk) disable iff (rst)
		trigger_wr |=> status_q.sleep_request_smi_flag)
		else $error("trigger write did not set SMI flag");

	chk_other_type: assert property (@(posedge clk) disable iff (rst)
		trigger_wr && !sleep_redirect_select && type_d != pm1_ctrl_pkg::SLEEP_TYPE_OFF && !pending_q
			|=> !pending_q)
		else $error("nonzero sleep type started a transition");

	chk_zero_write: assert property (@(posedge clk) disable iff (rst)
		io_req.wr && io_req.addr == pm1_ctrl_pkg::OFS_CONTROL_TWO
			&& !io_req.wdata[pm1_ctrl_pkg::BIT_SLEEP_TRIGGER] |=> !smi_q)
		else $error("zero trigger write had an effect");

	chk_wake_event: assert property (@(posedge clk) disable iff (rst)
		press_pulse && sleeping_now |=> wake_q && power_on_request_n_oe_q)
		else $error("press while off did not wake");

	cov_soft_off: cover property (@(posedge clk) disable iff (rst)
		$fell(power_on_request_n_oe_q) && $past(pending_q));
	cov_override: cover property (@(posedge clk) disable iff (rst) override_pulse);
	cov_redirect: cover property (@(posedge clk) disable iff (rst) smi_q);
	cov_wake: cover property (@(posedge clk) disable iff (rst) wake_q);

endmodule // acpi_pm1_button_sleep_control

/* File: verilog/button_override_timer.sv */
/*
 * Power button sampler and hold timer in the 32 kHz tick domain.
 * Assumes button_in is an asynchronous active-high pin and tick is a
 * one-cycle enable on clk.
 */
`timescale 1ns/1ns
module button_override_timer #(
	parameter int OVERRIDE_TICKS = pm1_ctrl_pkg::OVERRIDE_TICKS
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic tick,
	input  wire logic button_in,
	input  wire logic override_enable,
	output logic      press_pulse_q,
	output logic      override_pulse_q
);
	localparam int CW = $clog2(OVERRIDE_TICKS + 1);

	logic          sync1_q, sync1_d, sync2_q, sync2_d;
	logic          held_q, held_d;
	logic          fired_q, fired_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          press_d, override_d;

	always_comb begin
		sync1_d    = button_in;
		sync2_d    = sync1_q;
		held_d     = held_q;
		fired_d    = fired_q;
		cnt_d      = cnt_q;
		press_d    = 1'b0;
		override_d = 1'b0;
		// Hold is measured only in whole ticks, so the press is sampled on the tick too
		if (tick) begin
			held_d = sync2_q;
			if (!sync2_q) begin
				cnt_d   = '0;
				fired_d = 1'b0;
			end else if (!held_q) begin
				press_d = 1'b1;
				cnt_d   = '0;
			end else if (cnt_q != CW'(OVERRIDE_TICKS)) begin
				cnt_d = cnt_q + CW'(1);
			end else if (!fired_q && override_enable) begin
				// One override per press; the counter saturates while held
				override_d = 1'b1;
				fired_d    = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q          <= 1'b0;
			sync2_q          <= 1'b0;
			held_q           <= 1'b0;
			fired_q          <= 1'b0;
			cnt_q            <= '0;
			press_pulse_q    <= 1'b0;
			override_pulse_q <= 1'b0;
		end else begin
			sync1_q          <= sync1_d;
			sync2_q          <= sync2_d;
			held_q           <= held_d;
			fired_q          <= fired_d;
			cnt_q            <= cnt_d;
			press_pulse_q    <= press_d;
			override_pulse_q <= override_d;
		end
	end

	chk_override_enabled: assert property (@(posedge clk) disable iff (rst)
		override_pulse_q |-> $past(override_enable) && $past(cnt_q) == CW'(OVERRIDE_TICKS))
		else $error("override fired without enable or before full hold");

	chk_press_single: assert property (@(posedge clk) disable iff (rst)
		press_pulse_q |=> !press_pulse_q)
		else $error("press pulse longer than one cycle");

endmodule // button_override_timer

/* File: verilog/pm1_ctrl_pkg.sv */
/*
 * Shared constants and carrier types for the fixed-feature power
 * management enable and control registers.
 * Assumes a 125 MHz core clock and a 32 kHz tick made from it by a divider.
 */
package pm1_ctrl_pkg;

	// Offsets within the power management block in system I/O space
	localparam logic [4:0] OFS_ENABLE_ONE  = 5'h02;
	localparam logic [4:0] OFS_ENABLE_TWO  = 5'h03;
	localparam logic [4:0] OFS_CONTROL_ONE = 5'h04;
	localparam logic [4:0] OFS_CONTROL_TWO = 5'h05;

	// Field positions
	localparam int BIT_BUTTON_EVENT_EN = 0;
	localparam int BIT_SCI_GLOBAL_EN   = 0;
	localparam int BIT_OVERRIDE_EN     = 1;
	localparam int SLEEP_TYPE_LSB      = 2;
	localparam int SLEEP_TYPE_MSB      = 4;
	localparam int BIT_SLEEP_TRIGGER   = 5;

	// Reset values and the soft-off sleep type
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [2:0] SLEEP_TYPE_OFF  = 3'h0;

	// Timing
	localparam int CLK_PERIOD_NS  = 8;
	localparam int TICK_PERIOD_NS = 31250;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_RATE_HZ   = 32000;
	localparam int OVERRIDE_S     = 4;
	localparam int OVERRIDE_TICKS = OVERRIDE_S * TICK_RATE_HZ;
	localparam int SLEEP_DELAY_TICKS = 2;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} io_req_s;

	typedef struct packed {
		logic power_button_status;
		logic button_override_status;
		logic sleep_request_smi_flag;
	} status_flags_s;

endpackage
